/* event_irq_pkg.sv */
// Purpose: Constants and types for the panel event interrupt unit.
// Assumes: Byte-wide configuration register port on the configuration clock.
// Notes: Functional notes follow.
// Functional notes
// - The unit drives one interrupt pin that is active low.
// - The pin is low while any event flag is high and released otherwise.
// - Six sources each own a flag: mode, auto, fifo, overlay, output, input.
// - Mode flag sets on an enabled mode bit toggle, big change or sync jitter.
// - Auto flag sets when an auto-adjust measurement completes.
// - Fifo flag sets whenever the decoupling fifo becomes full.
// - Overlay flag sets each time a pointer animation sequence ends.
// - Output flag sets when the pixel stream to the output interface breaks.
// - Line flag sets when hsync jitter count exceeds the programmed limit.
// - All flags read back in the status register at address fe.
// - A flag stays high until software writes 1 to its bit; 0 keeps it.
// - Each condition is gated by its mask bit at fd, 1 enabling it.
package event_irq_pkg;
    localparam logic [7:0] ADDR_EVENT_ENABLE_MASK = 8'hfd;
    localparam logic [7:0] ADDR_EVENT_FLAG_STATUS = 8'hfe;
    localparam int NUM_EVENTS = 6;
    localparam int BIT_MODE = 0;
    localparam int BIT_AUTO = 1;
    localparam int BIT_FIFO = 2;
    localparam int BIT_OSD = 3;
    localparam int BIT_OIF = 4;
    localparam int BIT_IIF = 5;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] JITTER_LIMIT_RESET = 8'h00;

    typedef struct packed {
        logic mode_change;
        logic auto_done;
        logic fifo_full;
        logic osd_seq_end;
        logic oif_break;
        logic hsync_jitter;
    } event_src_s;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cfg_req_s;
endpackage : event_irq_pkg

/* panel_event_interrupt_unit.sv */
// Purpose: Sticky event flags with mask and active-low interrupt pin.
// Assumes: Event inputs are single-cycle pulses on the configuration clock.
// Notes: Registers not at fd or fe read as zero.
`timescale 1ns/1ps
`default_nettype none
module panel_event_interrupt_unit
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire event_irq_pkg::cfg_req_s cfg_i,
    input wire event_irq_pkg::event_src_s event_i,
    input wire logic [7:0] jitter_count_limit_i,
    output logic [7:0] cfg_rdata_o,
    output logic int_n_o
);
    import event_irq_pkg::*;

    // ------------------------------------------------------------
    // Address match
    // ------------------------------------------------------------
    // One compare serves both the write strobes and the read mux.
    function automatic logic addr_hits(
        input logic [7:0] addr,
        input logic [7:0] target
    );
        return addr == target;
    endfunction : addr_hits

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    logic [7:0] event_enable_mask;
    logic [7:0] event_flag_status;
    logic [7:0] jitter_count;
    logic int_n;
    wire sel_mask = addr_hits(cfg_i.addr, ADDR_EVENT_ENABLE_MASK);
    wire sel_stat = addr_hits(cfg_i.addr, ADDR_EVENT_FLAG_STATUS);
    wire wr_mask = cfg_i.wr && sel_mask;
    wire wr_stat = cfg_i.wr && sel_stat;
    wire [7:0] clear_bits = wr_stat ? cfg_i.wdata : 8'h00;

    // ------------------------------------------------------------
    // Line jitter counting
    // ------------------------------------------------------------
    // The count restarts once it trips so repeated bursts raise new events.
    wire jitter_trip = event_i.hsync_jitter
        && (jitter_count >= jitter_count_limit_i);
    wire [7:0] next_jitter_count = jitter_trip ? 8'h00
        : (event_i.hsync_jitter ? jitter_count + 8'h01 : jitter_count);

    // ------------------------------------------------------------
    // Flag update
    // ------------------------------------------------------------
    wire [NUM_EVENTS-1:0] raw_events;
    assign raw_events[BIT_MODE] = event_i.mode_change;
    assign raw_events[BIT_AUTO] = event_i.auto_done;
    assign raw_events[BIT_FIFO] = event_i.fifo_full;
    assign raw_events[BIT_OSD] = event_i.osd_seq_end;
    assign raw_events[BIT_OIF] = event_i.oif_break;
    assign raw_events[BIT_IIF] = jitter_trip;
    wire [NUM_EVENTS-1:0] set_bits =
        raw_events & event_enable_mask[NUM_EVENTS-1:0];
    wire [NUM_EVENTS-1:0] next_flags;
    genvar g;
    generate
        for (g = 0; g < NUM_EVENTS; g++)
        begin : g_flag
            // Set wins over clear so an event never slips past a write.
            assign next_flags[g] = set_bits[g]
                | (event_flag_status[g] & ~clear_bits[g]);
        end
    endgenerate
    // The two spare bits stay zero so software may write ones there.
    wire [7:0] next_status = {2'b00, next_flags};
    wire next_int_n = ~(|next_status);

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            event_enable_mask <= MASK_RESET;
            event_flag_status <= STATUS_RESET;
            jitter_count <= JITTER_LIMIT_RESET;
            int_n <= 1'b1;
        end
        else
        begin
            if (wr_mask)
                event_enable_mask <= cfg_i.wdata;
            event_flag_status <= next_status;
            jitter_count <= next_jitter_count;
            int_n <= next_int_n;
        end
    end

    // ------------------------------------------------------------
    // Read back and pin
    // ------------------------------------------------------------
    // Unmapped addresses read zero so a stray read never shows a flag.
    wire [7:0] read_word = sel_stat ? event_flag_status
        : (sel_mask ? event_enable_mask : 8'h00);

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            cfg_rdata_o <= 8'h00;
        else
            cfg_rdata_o <= read_word;
    end

    assign int_n_o = int_n;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    pin_follows_flags_a: assert property (
        (|event_flag_status) == !int_n_o)
        else $error("interrupt pin does not follow flags");
    pin_low_active_a: assert property (
        (event_enable_mask[BIT_AUTO] && event_i.auto_done) |=> !int_n_o)
        else $error("pin not low after enabled event");
    masked_no_set_a: assert property (
        (!event_enable_mask[BIT_FIFO] && !event_flag_status[BIT_FIFO])
        |=> !event_flag_status[BIT_FIFO])
        else $error("masked fifo event set flag");
    mode_sets_a: assert property (
        (event_enable_mask[BIT_MODE] && event_i.mode_change)
        |=> event_flag_status[BIT_MODE])
        else $error("mode flag not set");
    osd_sets_a: assert property (
        (event_enable_mask[BIT_OSD] && event_i.osd_seq_end)
        |=> event_flag_status[BIT_OSD])
        else $error("overlay flag not set");
    oif_sets_a: assert property (
        (event_enable_mask[BIT_OIF] && event_i.oif_break)
        |=> event_flag_status[BIT_OIF])
        else $error("output flag not set");
    fifo_sets_a: assert property (
        (event_enable_mask[BIT_FIFO] && event_i.fifo_full)
        |=> event_flag_status[BIT_FIFO])
        else $error("fifo flag not set");
    auto_sets_a: assert property (
        (event_enable_mask[BIT_AUTO] && event_i.auto_done)
        |=> event_flag_status[BIT_AUTO])
        else $error("auto flag not set");
    jitter_gate_a: assert property (
        (event_i.hsync_jitter && jitter_count < jitter_count_limit_i
        && !event_flag_status[BIT_IIF]) |=> !event_flag_status[BIT_IIF])
        else $error("line flag set below limit");
    clear_one_a: assert property (
        (wr_stat && cfg_i.wdata[BIT_OSD] && !event_i.osd_seq_end)
        |=> !event_flag_status[BIT_OSD])
        else $error("write one did not clear");
    sticky_hold_a: assert property (
        (event_flag_status[BIT_MODE] && !clear_bits[BIT_MODE])
        |=> event_flag_status[BIT_MODE])
        else $error("flag dropped without clear");
    set_wins_a: assert property (
        (wr_stat && cfg_i.wdata[BIT_OIF] && event_i.oif_break
        && event_enable_mask[BIT_OIF]) |=> event_flag_status[BIT_OIF])
        else $error("event lost under clear");
    status_read_a: assert property (
        (cfg_i.addr == ADDR_EVENT_FLAG_STATUS)
        |=> cfg_rdata_o == $past(event_flag_status))
        else $error("status read mismatch");
    six_sources_a: assert property (
        event_flag_status[7:6] == 2'b00)
        else $error("unused flag bits set");


    // ------------------------------------------------------------
    // Clear checks
    // ------------------------------------------------------------
    // Each flag must drop on its own one, with no event pending.
    clear_auto_a: assert property (
        (wr_stat && cfg_i.wdata[BIT_AUTO] && !event_i.auto_done)
        |=> !event_flag_status[BIT_AUTO])
        else $error("auto flag not cleared");

    clear_fifo_a: assert property (
        (wr_stat && cfg_i.wdata[BIT_FIFO] && !event_i.fifo_full)
        |=> !event_flag_status[BIT_FIFO])
        else $error("fifo flag not cleared");

    clear_mode_a: assert property (
        (wr_stat && cfg_i.wdata[BIT_MODE] && !event_i.mode_change)
        |=> !event_flag_status[BIT_MODE])
        else $error("mode flag not cleared");

    clear_oif_a: assert property (
        (wr_stat && cfg_i.wdata[BIT_OIF] && !event_i.oif_break)
        |=> !event_flag_status[BIT_OIF])
        else $error("output flag not cleared");

    clear_iif_a: assert property (
        (wr_stat && cfg_i.wdata[BIT_IIF] && !jitter_trip)
        |=> !event_flag_status[BIT_IIF])
        else $error("line flag not cleared");

    zero_keeps_a: assert property (
        (wr_stat && !cfg_i.wdata[BIT_FIFO] && event_flag_status[BIT_FIFO])
        |=> event_flag_status[BIT_FIFO])
        else $error("write of zero cleared flag");

    // ------------------------------------------------------------
    // Jitter checks
    // ------------------------------------------------------------
    // The counter only moves on a jitter pulse and wraps on a trip.
    jitter_sets_a: assert property (
        (event_enable_mask[BIT_IIF] && jitter_trip)
        |=> event_flag_status[BIT_IIF])
        else $error("line flag not set on trip");

    jitter_wrap_a: assert property (
        jitter_trip |=> (jitter_count == 8'h00))
        else $error("jitter count not restarted");

    jitter_step_a: assert property (
        (event_i.hsync_jitter && !jitter_trip)
        |=> (jitter_count == $past(jitter_count) + 8'h01))
        else $error("jitter count did not step");

    jitter_hold_a: assert property (
        !event_i.hsync_jitter |=> $stable(jitter_count))
        else $error("jitter count moved without pulse");

    // ------------------------------------------------------------
    // Mask and read checks
    // ------------------------------------------------------------
    // The mask gates only the setting of flags, never the pin itself.
    mask_write_a: assert property (
        wr_mask |=> (event_enable_mask == $past(cfg_i.wdata)))
        else $error("mask write lost");

    mask_hold_a: assert property (
        !wr_mask |=> $stable(event_enable_mask))
        else $error("mask changed without write");

    masked_mode_a: assert property (
        (!event_enable_mask[BIT_MODE] && !event_flag_status[BIT_MODE])
        |=> !event_flag_status[BIT_MODE])
        else $error("masked mode event set flag");

    masked_osd_a: assert property (
        (!event_enable_mask[BIT_OSD] && !event_flag_status[BIT_OSD])
        |=> !event_flag_status[BIT_OSD])
        else $error("masked overlay event set flag");

    masked_auto_a: assert property (
        (!event_enable_mask[BIT_AUTO] && !event_flag_status[BIT_AUTO])
        |=> !event_flag_status[BIT_AUTO])
        else $error("masked auto event set flag");

    masked_oif_a: assert property (
        (!event_enable_mask[BIT_OIF] && !event_flag_status[BIT_OIF])
        |=> !event_flag_status[BIT_OIF])
        else $error("masked output event set flag");

    masked_iif_a: assert property (
        (!event_enable_mask[BIT_IIF] && !event_flag_status[BIT_IIF])
        |=> !event_flag_status[BIT_IIF])
        else $error("masked line event set flag");

    mask_read_a: assert property (
        sel_mask |=> (cfg_rdata_o == $past(event_enable_mask)))
        else $error("mask read mismatch");

    other_read_a: assert property (
        (!sel_mask && !sel_stat) |=> (cfg_rdata_o == 8'h00))
        else $error("unmapped read not zero");

    pin_drop_a: assert property (
        (|set_bits) |=> !int_n_o)
        else $error("pin not low after set");

    // ------------------------------------------------------------
    // Scenario covers
    // ------------------------------------------------------------
    clear_cov_c: cover property (wr_stat ##1 (event_flag_status == 8'h00));
    mask_cov_c: cover property (wr_mask ##1 (event_enable_mask != 8'h00));
    irq_cov_c: cover property (int_n_o ##1 !int_n_o);
    jitter_cov_c: cover property (jitter_trip);
    race_cov_c: cover property (wr_stat && |set_bits);
endmodule : panel_event_interrupt_unit
`default_nettype wire

/* irq_host_model.sv */
// Purpose: Host side watcher of the interrupt pin.
// Assumes: The host shares the configuration clock.
// Notes: Counts each new request seen on the pin.
`timescale 1ns/1ps
`default_nettype none
module irq_host_model
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic int_n_i,
    output logic [7:0] irq_count_o
);
    logic last_n;
    always_ff @(posedge clk_i)
    begin
        last_n <= rst_i | int_n_i;
        if (rst_i)
            irq_count_o <= 8'h00;
        else if (last_n && !int_n_i)
            irq_count_o <= irq_count_o + 8'h01;
    end
endmodule : irq_host_model
`default_nettype wire

/* panel_event_interrupt_unit_tb.sv */
// Purpose: Self-checking bench for the panel event interrupt unit.
// Assumes: Read data is registered one cycle after the address.
// Notes: The host clears flags, so the bench keeps its own copy.
`timescale 1ns/1ps
`default_nettype none
module panel_event_interrupt_unit_tb;
    import event_irq_pkg::*;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    cfg_req_s cfg = '0;
    event_src_s ev = '0;
    logic [7:0] lim = 8'h00;
    logic [7:0] rdata;
    logic int_n;
    logic [7:0] irqs;
    logic [7:0] mask_m = 8'h00;
    logic [7:0] stat_m = 8'h00;
    int bad_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    panel_event_interrupt_unit panel_event_interrupt_unit_inst (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .cfg_i(cfg), .event_i(ev),
        .jitter_count_limit_i(lim), .cfg_rdata_o(rdata), .int_n_o(int_n));
    irq_host_model irq_host_model_inst (.clk_i(clk_i), .rst_i(sys_rst_i),
        .int_n_i(int_n), .irq_count_o(irqs));
    initial
    begin
        forever #2 clk_i = ~clk_i;
    end
    function automatic event_src_s to_ev(input logic [5:0] b);
        return {b[0], b[1], b[2], b[3], b[4], b[5]};
    endfunction : to_ev
    function automatic logic [7:0] exp_rd(input logic [7:0] a);
        return a == 8'hfd ? mask_m : (a == 8'hfe ? stat_m : 8'h00);
    endfunction : exp_rd
    task automatic chk(input string n, input logic [7:0] e, logic [7:0] g);
        cmp_count++;
        if (g !== e)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        cfg <= '{1'b1, 1'b0, a, d};
        @(posedge clk_i);
        cfg.wr <= 1'b0;
        if (a == 8'hfd) mask_m = d;
        if (a == 8'hfe) stat_m = stat_m & ~d;
    endtask : wr
    // Every read also checks that the pin follows the flags.
    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        cfg.addr <= a;
        @(posedge clk_i);
        #1;
        chk("rdata", exp_rd(a), rdata);
        chk("int_n", {7'h00, stat_m == 8'h00}, {7'h00, int_n});
    endtask : rd
    task automatic pulse(input logic [5:0] b, input logic [5:0] eff);
        @(posedge clk_i);
        ev <= to_ev(b);
        @(posedge clk_i);
        ev <= '0;
        stat_m = stat_m | {2'b00, eff & mask_m[5:0]};
    endtask : pulse
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : report_and_stop
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            report_and_stop();
        end
    end
    initial
    begin
        logic [5:0] b;
        logic [7:0] n;
        void'($urandom(32'h83d3));
        repeat (8) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd(8'hfd);
        rd(8'hfe);
        pulse(6'h3f, 6'h3f);
        rd(8'hfe);
        $display("test reset_and_masked done");
        repeat (200)
        begin
            b = 6'($urandom);
            wr(8'hfd, 8'($urandom));
            pulse(b, b);
            rd(8'hfe);
            wr(8'($urandom), 8'($urandom));
            rd(8'($urandom));
            rd(8'hfe);
        end
        $display("test random_events done");
        wr(8'hfd, 8'h3f);
        pulse(6'h01, 6'h01);
        @(posedge clk_i);
        cfg <= '{1'b1, 1'b0, 8'hfe, 8'h01};
        ev <= to_ev(6'h01);
        @(posedge clk_i);
        cfg.wr <= 1'b0;
        ev <= '0;
        rd(8'hfe);
        $display("test set_beats_clear done");
        n = 8'(1 + $urandom % 4);
        lim <= n;
        wr(8'hfe, 8'h3f);
        repeat (n) pulse(6'h20, 6'h00);
        rd(8'hfe);
        pulse(6'h20, 6'h20);
        rd(8'hfe);
        chk("irqs", 8'h00, 8'(irqs == 8'h00));
        $display("test jitter_limit done");
        report_and_stop();
    end
endmodule : panel_event_interrupt_unit_tb
`default_nettype wire
